// *** dv/sink_link_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Checks on the link pins and the sink lines.
module sink_link_monitor (
  input wire logic       clock_i,             // Clock.
  input wire logic       nrst_i,              // Reset, active low.
  input wire logic       sclk,                // Shift clock.
  input wire logic       sdata,               // Serial in.
  input wire logic       sdata_out,           // Serial out.
  input wire logic       latch_strobe_ctrl,   // Strobe.
  input wire logic       oe_n,                // Enable, active low.
  input wire logic [7:0] sink_driver_lines_o  // Sinks.
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // A held disable forces every sink off.
  property p_oe_off;
    oe_n [*6] |-> sink_driver_lines_o == 8'h00;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Sinks on while disabled.");

  // Reset leaves sink lines and serial out clear.
  property p_rst_zero;
    $rose(nrst_i) |-> sink_driver_lines_o == 8'h00 && !sdata_out;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("State not clear after reset.");

  // Serial out moves only after a rising shift clock.
  property p_sout_hold;
    (!sclk) [*8] |-> $stable(sdata_out);
  endproperty
  a_sout_hold: assert property (p_sout_hold) else $error("Serial out moved.");

  // Closed latches keep enabled sinks steady while shifting goes on.
  property p_latch_hold;
    (!oe_n && !latch_strobe_ctrl) [*8] |-> $stable(sink_driver_lines_o);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("Sinks moved.");

  // High phase of the shift clock lasts seven cycles.
  property p_sclk_high;
    $rose(sclk) |-> sclk [*7] ##1 !sclk;
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("Short clock high.");

  // Low phase of the shift clock lasts seven cycles at least.
  property p_sclk_low;
    $fell(sclk) |-> (!sclk) [*7];
  endproperty
  a_sclk_low: assert property (p_sclk_low) else $error("Short clock low.");

  // Data is steady around the capturing edge.
  property p_setup;
    $rose(sclk) |-> $stable(sdata) [*4];
  endproperty
  a_setup: assert property (p_setup) else $error("Data moved at edge.");

  // Strobe pulse lasts thirteen cycles with the shift clock low.
  property p_strobe;
    $rose(latch_strobe_ctrl) |-> (latch_strobe_ctrl && !sclk) [*8] ##1
      (latch_strobe_ctrl && !sclk) [*5] ##1 !latch_strobe_ctrl;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Bad strobe pulse.");
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host and driver joined by the link, checked at the sinks.
module testbench;
  logic       clock_i   = 1'b0;
  logic       nrst_i    = 1'b0;
  logic       valid_i   = 1'b0;
  logic [7:0] data_i    = 8'h00;
  logic       oe_n_i    = 1'b1;
  logic       ready_o;
  logic       done_o;
  logic [7:0] lines;
  int         errors    = 0;
  int         cmp_count = 0;
  int         dones     = 0;
  int         n;
  logic [8:0] rows [4]  = '{9'h0a5, 9'h13c, 9'h0ff, 9'h001}; // Enable and frame.

  sink_link_if link_if ();
  sink_drv_host sink_drv_host_inst (.clock_i, .nrst_i, .valid_i, .data_i, .ready_o,
    .oe_n_i, .done_o, .link(link_if));
  sink_drv_dev sink_drv_dev_inst (.clock_i, .nrst_i, .link(link_if),
    .sink_driver_lines_o(lines));
  sink_link_monitor sink_link_monitor_inst (.clock_i, .nrst_i, .sclk(link_if.sclk),
    .sdata(link_if.sdata), .sdata_out(link_if.sdata_out), .oe_n(link_if.oe_n),
    .latch_strobe_ctrl(link_if.latch_strobe_ctrl), .sink_driver_lines_o(lines));

  // Clock and a count of finished frames.
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) if (done_o === 1'b1) dones <= dones + 1;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Stops the run when a bounded wait runs out.
  task automatic bound_hit();
    if (n >= 3000)
    begin
      errors++;
      $display("[ERR] %0t wait ran out", $time);
      complete_run();
    end
  endtask

  // Offers one frame and holds it until taken.
  task automatic send(input logic [7:0] d);
    @(posedge clock_i);
    #1 valid_i = 1'b1;
    data_i = d;
    for (n = 0; ready_o !== 1'b1 && n < 3000; n++) @(posedge clock_i) #1;
    bound_hit();
    @(posedge clock_i);
    #1 valid_i = 1'b0;
  endtask

  task automatic wait_dones(input int target);
    for (n = 0; dones < target && n < 3000; n++) @(posedge clock_i);
    bound_hit();
    repeat (8) @(posedge clock_i);
    #1;
  endtask

  // Main sequence: table, enable toggle, held latches, stall, reset.
  initial
  begin
    repeat (16) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    check({lines[6:0], link_if.sdata_out}, 8'h00);
    foreach (rows[i])
    begin
      oe_n_i = rows[i][8];
      send(rows[i][7:0]);
      wait_dones(i + 1);
      check(lines, rows[i][8] ? 8'h00 : rows[i][7:0]);
      check({7'h00, link_if.sdata_out}, {7'h00, rows[i][7]});
    end
    $display("Table test done");
    oe_n_i = 1'b1;
    repeat (8) @(posedge clock_i);
    #1 check(lines, 8'h00);
    oe_n_i = 1'b0;
    repeat (8) @(posedge clock_i);
    #1 check(lines, 8'h01);
    send(8'h80);
    repeat (60) @(posedge clock_i);
    #1 check(lines, 8'h01);
    send(8'h5a);
    send(8'hc3);
    wait_dones(7);
    check(lines, 8'hc3);
    $display("Enable, hold and stall tests done");
    send(8'hff);
    repeat (40) @(posedge clock_i);
    #1 nrst_i = 1'b0;
    @(posedge clock_i);
    #1 check({lines[6:0], link_if.sdata_out}, 8'h00);
    nrst_i = 1'b1;
    $display("Reset test done");
    complete_run();
  end
endmodule

`default_nettype wire

// *** pkg/sink_drv_pkg.sv ***
package sink_drv_pkg;
  // States of the host load sequence.
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LOW,
    HS_HIGH,
    HS_STROBE,
    HS_DONE
  } host_state_t;

  // One frame of parallel sink data.
  typedef logic [7:0] frame_t;
endpackage

// *** pkg/sink_drv_regs.svh ***
`ifndef SINK_DRV_REGS_SVH
`define SINK_DRV_REGS_SVH

// Number of shift stages, latches and sink lines.
`define SINK_STAGES 8
// Reset value of shift register and latches.
`define SINK_RST_VAL 8'h00
// Shift clock limit in kHz and the clock rate in kHz.
`define SINK_SCLK_MAX_KHZ 10000
`define SINK_CLK_KHZ 125000
// Half period of the generated shift clock, in clock cycles (round up).
`define SINK_HALF_CYC ((`SINK_CLK_KHZ + 2 * `SINK_SCLK_MAX_KHZ - 1) / (2 * `SINK_SCLK_MAX_KHZ))

`endif

// *** pkg/sink_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none

// Pins between the host and the sink driver.
interface sink_link_if;
  logic sclk;               // Shift clock, rising edge shifts.
  logic sdata;              // Serial data into the driver.
  logic sdata_out;          // Serial data out of the driver, for cascading.
  logic latch_strobe_ctrl;  // Latch strobe, high makes latches transparent.
  logic oe_n;               // Output enable, active low.

  modport host (output sclk, output sdata, output latch_strobe_ctrl, output oe_n,
                input sdata_out);
  modport dev  (input sclk, input sdata, input latch_strobe_ctrl, input oe_n,
                output sdata_out);
endinterface

`default_nettype wire

// *** src/sink_drv_dev.sv ***
// Summary of operation
// - Rising shift clock captures data into stage one.
// - Eight stages shift toward serial output.
// - Host sets data before capturing rising edge.
// - Strobe high makes latches follow stages.
// - Latches keep following across shifts.
// - Output enable high forces sinks off.
// - Output enable never changes stored data.
// - Enabled outputs show own latch.
// - Bypassed latches need enable high while loading.
// - Reset brings register and latches to zero.
// - Shift clock at most 10 MHz.
// - Serial output allows cascading devices.
`timescale 1ns/1ps
`default_nettype none
`include "sink_drv_regs.svh"

// ==========================================================================
// Overview
// The driver end of the link. Every pin from the host is an input from
// outside the clock's domain, so each one passes two flip-flops before any
// logic reads it. The shift clock is not used as a clock: the system clock
// samples it and a rising edge is found by comparing the synchronised level
// with the level one cycle earlier.
// All pins pass the same depth of synchronisers, so the data bit seen on
// the cycle of a detected edge is the one that stood on the pin when the
// edge arrived there. The host must therefore hold the data level for a few
// system clock cycles on either side of its rising shift clock edge.
// The latches are modelled by clock-sampled flip-flops. While the strobe is
// high they take the stage contents of the same cycle, including a shift
// that happens in that cycle, so no shifted value is missed.
// Latency from a pin change to the sink lines is three to four system
// clock cycles; the serial output follows a shift by one cycle.

module sink_drv_dev #(
  parameter int STAGES = `SINK_STAGES
) (
  input  wire logic              clock_i,            // System clock.
  input  wire logic              nrst_i,             // Asynchronous reset, active low.
  sink_link_if.dev               link,               // Pins from the host.
  output logic [STAGES-1:0]      sink_driver_lines_o // Sink outputs, high means sinking.
);

  // ==========================================================================
  // Parameter check
  initial
  begin
    if (STAGES < 2) $error("Stage count must be two or more.");
  end

  // ==========================================================================
  // Input synchronisers
  logic [1:0] sclk_s_r;  // Shift clock pin, two stages.
  logic [1:0] sdat_s_r;  // Serial data pin, two stages.
  logic [1:0] strb_s_r;  // Latch strobe pin, two stages.
  logic [1:0] oen_s_r;   // Output enable pin, two stages.
  logic       sclk_d_r;  // Synchronised shift clock, one cycle late.
  logic       sclk_rise; // One-cycle pulse on a rising shift clock.

  // Shift clock pin; the reset level matches its idle level, so no false edge.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sclk_s_r <= 2'h0;
    else
      sclk_s_r <= {sclk_s_r[0], link.sclk};
  end

  // Serial data pin, kept as deep as the clock path to stay aligned.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sdat_s_r <= 2'h0;
    else
      sdat_s_r <= {sdat_s_r[0], link.sdata};
  end

  // Latch strobe pin.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      strb_s_r <= 2'h0;
    else
      strb_s_r <= {strb_s_r[0], link.latch_strobe_ctrl};
  end

  // Output enable pin; resets to the disabled level so sinks start off.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      oen_s_r <= 2'h3;
    else
      oen_s_r <= {oen_s_r[0], link.oe_n};
  end

  // Previous synchronised shift clock level, for edge detection.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sclk_d_r <= 1'h0;
    else
      sclk_d_r <= sclk_s_r[1];
  end

  // Rising edge of the synchronised shift clock; data sync keeps it aligned.
  assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;

  // ==========================================================================
  // Shift register
  logic [STAGES-1:0] shift_r;

  // Stage contents after one shift that takes the given serial bit.
  function automatic logic [STAGES-1:0] shifted(input logic [STAGES-1:0] stages,
                                                input logic              bit_in);
    shifted = {stages[STAGES-2:0], bit_in};
  endfunction

  // Capture into stage one and move each stage up on a rising edge.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      shift_r <= `SINK_RST_VAL;
    else if (sclk_rise)
      shift_r <= shifted(shift_r, sdat_s_r[1]);
  end

  // ==========================================================================
  // Latches
  logic [STAGES-1:0] latch_r;

  // Latches follow the stages while the strobe is high, else hold.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      latch_r <= `SINK_RST_VAL;
    else if (strb_s_r[1])
      latch_r <= sclk_rise ? shifted(shift_r, sdat_s_r[1]) : shift_r;
    // Strobe low: latch_r keeps its value.
  end

  // ==========================================================================
  // Outputs
  // Sink lines: enable only gates the output flops; stored data is untouched.
  // A disabled driver shows all sinks off, an enabled one its own latches.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sink_driver_lines_o <= '0;
    else
      sink_driver_lines_o <= oen_s_r[1] ? '0 : latch_r;
  end

  // Serial output for a chained driver: the last stage, which changes only
  // after a detected rising shift clock and holds otherwise.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      link.sdata_out <= 1'h0;
    else
      link.sdata_out <= shift_r[STAGES-1];
  end

endmodule

`default_nettype wire

// *** src/sink_drv_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sink_drv_regs.svh"

module sink_drv_host #(
  parameter int HALF_CYC = `SINK_HALF_CYC,
  parameter int WIDTH    = `SINK_STAGES
) (
  input  wire logic             clock_i,   // System clock.
  input  wire logic             nrst_i,    // Asynchronous reset, active low.
  input  wire logic             valid_i,   // Frame offered.
  input  wire logic [WIDTH-1:0] data_i,    // Frame, bit WIDTH-1 shifted first.
  output logic                  ready_o,   // Buffer can take a frame.
  input  wire logic             oe_n_i,    // Requested output enable, active low.
  output logic                  done_o,    // Pulse when a frame is strobed.
  sink_link_if.host             link       // Pins to the driver.
);

  // ==========================================================================
  // Parameter check
  initial
  begin
    if (HALF_CYC < 1 || HALF_CYC > 65536 || WIDTH < 2 || WIDTH > 255)
      $error("Bad host parameters.");
  end

  // ==========================================================================
  // Two-entry buffer
  logic [WIDTH-1:0] buf_r [2];
  logic             wp_r;
  logic             rp_r;
  logic [1:0]       cnt_r;
  logic             take;
  logic             push;

  assign push = valid_i & ready_o;

  // Frames wait here until the shifter takes them; ready drops when full.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_r    <= 1'h0;
      rp_r    <= 1'h0;
      cnt_r   <= 2'h0;
      ready_o <= 1'h1;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
    end
    else
    begin
      if (push)
      begin
        buf_r[wp_r] <= data_i;
        wp_r        <= ~wp_r;
      end
      if (take)
        rp_r <= ~rp_r;
      cnt_r   <= 2'(cnt_r + {1'h0, push} - {1'h0, take});
      ready_o <= (2'(cnt_r + {1'h0, push} - {1'h0, take})) != 2'h2;
    end
  end

  // ==========================================================================
  // Shift sequencer
  sink_drv_pkg::host_state_t st_r;
  logic [WIDTH-1:0]          sh_r;
  logic [7:0]                bits_r;
  logic [15:0]               tick_r;
  logic                      tick_end;

  assign tick_end = (tick_r == 16'(HALF_CYC - 1));
  assign take     = (st_r == sink_drv_pkg::HS_IDLE) && (cnt_r != 2'h0);

  // Each clock phase lasts HALF_CYC cycles, keeping the clock at 10 MHz or less.
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r                   <= sink_drv_pkg::HS_IDLE;
      sh_r                   <= '0;
      bits_r                 <= 8'h00;
      tick_r                 <= 16'h0000;
      done_o                 <= 1'h0;
      link.sclk              <= 1'h0;
      link.sdata             <= 1'h0;
      link.latch_strobe_ctrl <= 1'h0;
      link.oe_n              <= 1'h1;
    end
    else
    begin
      done_o    <= 1'h0;
      link.oe_n <= oe_n_i;
      tick_r    <= (st_r == sink_drv_pkg::HS_IDLE || tick_end) ? 16'h0000 : tick_r + 16'h0001;
      case (st_r)
        sink_drv_pkg::HS_IDLE:
        begin
          if (take)
          begin
            sh_r       <= buf_r[rp_r];
            link.sdata <= buf_r[rp_r][WIDTH-1];
            bits_r     <= 8'(WIDTH);
            st_r       <= sink_drv_pkg::HS_LOW;
          end
        end
        sink_drv_pkg::HS_LOW:
          if (tick_end)
          begin
            link.sclk <= 1'h1;
            st_r      <= sink_drv_pkg::HS_HIGH;
          end
        sink_drv_pkg::HS_HIGH:
          if (tick_end)
          begin
            link.sclk <= 1'h0;
            sh_r      <= sh_r << 1;
            link.sdata <= sh_r[WIDTH-2];
            bits_r    <= bits_r - 8'h01;
            st_r      <= (bits_r == 8'h01) ? sink_drv_pkg::HS_STROBE : sink_drv_pkg::HS_LOW;
          end
        sink_drv_pkg::HS_STROBE:
        begin
          link.latch_strobe_ctrl <= 1'h1;
          if (tick_end)
            st_r <= sink_drv_pkg::HS_DONE;
        end
        sink_drv_pkg::HS_DONE:
          if (tick_end)
          begin
            link.latch_strobe_ctrl <= 1'h0;
            done_o                 <= 1'h1;
            st_r                   <= sink_drv_pkg::HS_IDLE;
          end
        default:
          st_r <= sink_drv_pkg::HS_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire
